// File: bss_params.svh
/*
 Offsets, field positions, reset values and decode constants for the
 boot strap source select block.
 Assumes inclusion by the package and the design modules of the block.
*/
`ifndef BSS_PARAMS_SVH
`define BSS_PARAMS_SVH

// ----------------------------------------------------------------------
// Strap field positions
// ----------------------------------------------------------------------
`define BSS_STRAP_W 16
`define BSS_XTAL_MSB 15
`define BSS_XTAL_LSB 14
`define BSS_RSV_MSB 13
`define BSS_RSV_LSB 12
`define BSS_RSV_OK 2'h0
`define BSS_AUX_BIT 5
`define BSS_PAT_MSB 4
`define BSS_PAT_LSB 0
`define BSS_PAT_DEFAULT 5'h1C
`define BSS_PAT_ALT 5'h18

// Crystal frequency in kHz per strap code
`define BSS_XTAL_KHZ_0 16'h4B00
`define BSS_XTAL_KHZ_1 16'h5DC0
`define BSS_XTAL_KHZ_2 16'h61A8
`define BSS_XTAL_KHZ_3 16'h6590

// ----------------------------------------------------------------------
// Register map (byte offsets) and fields
// ----------------------------------------------------------------------
`define BSS_OFF_STRAP 4'h0
`define BSS_OFF_STATUS 4'h4
`define BSS_OFF_ORDER 4'h8
`define BSS_OFF_CONTROL 4'hC
`define BSS_ST_XTAL_MSB 15
`define BSS_ST_XTAL_LSB 0
`define BSS_ST_AUX 16
`define BSS_ST_RSVERR 17
`define BSS_ST_KNOWN 18
`define BSS_ST_VALID 19
`define BSS_ORD_MSB 11
`define BSS_CTL_ATT_MSB 1
`define BSS_CTL_ATT_LSB 0
`define BSS_CTL_AUXOFF 8
`define BSS_CTL_ATT_RST 2'h0
`define BSS_CTL_AUXOFF_RST 1'h0
`define BSS_HSIZE_WORD 3'h2

`endif

// File: bss_pkg.sv
/*
 Types shared by the boot strap source select modules.
 Assumes bss_params.svh is on the include path.
*/
`include "bss_params.svh"

package bss_pkg;

   // Boot sources the ROM may try
   typedef enum logic [2:0] {
      SRC_NONE = 3'h0,
      SRC_ONBOARD_FLASH = 3'h1,
      SRC_REMOVABLE_CARD = 3'h2,
      SRC_FIRST_SERIAL = 3'h3,
      SRC_FIRST_USB = 3'h4,
      SRC_FIRST_SPI = 3'h5
   } bss_src_e;

   // Slot 0 is tried first
   typedef bss_src_e [3:0] bss_order_t;

   typedef enum logic [1:0] {
      ST_CAPTURE = 2'b01,
      ST_RUN = 2'b10
   } bss_state_e;

   typedef struct packed {
      logic [15:0] xtal_khz;
      logic aux_en;
      logic rsv_err;
      logic order_known;
      bss_order_t order;
   } bss_decode_s;

   typedef struct packed {
      logic done;
      logic [`BSS_STRAP_W-1:0] value;
   } bss_cap_s;

   typedef struct packed {
      logic sel;
      logic write;
      logic mapped;
      logic word;
      logic [3:0] addr;
   } bss_dphase_s;

endpackage : bss_pkg

// File: bss_strap_capture.sv
/*
 One-shot capture of the boot strap pins after reset release.
 Assumes the pins are synchronous to hclk and settled at release.
*/
`include "bss_params.svh"
module bss_strap_capture import bss_pkg::*; (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [`BSS_STRAP_W-1:0] boot_strap_bus,
   output logic cap_done,
   output logic [`BSS_STRAP_W-1:0] cap_value
);

   bss_cap_s r_reg;
   bss_cap_s r_next;

   // Sample once; later pin activity (header drivers) is ignored
   always_comb begin
      r_next = r_reg;
      if (!r_reg.done) begin
         r_next.value = boot_strap_bus; // see [R10]
         r_next.done = 1'b1;
      end
   end

   // Pins are caught by the clock, never by the reset itself
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign cap_done = r_reg.done;
   assign cap_value = r_reg.value;

endmodule : bss_strap_capture

// File: bss_boot_decode.sv
/*
 Decodes captured strap bits into crystal rate, clock enable and order.
 Assumes a stable strap word at its input.
*/
`include "bss_params.svh"
module bss_boot_decode import bss_pkg::*; (
   input wire logic [`BSS_STRAP_W-1:0] strap,
   output bss_decode_s dec
);

   // Only 15:12, 5 and 4:0 are looked at; 11:6 never reach the decode
   always_comb begin
      dec = '0;
      unique case (strap[`BSS_XTAL_MSB:`BSS_XTAL_LSB]) // see [R2]
         2'h0: dec.xtal_khz = `BSS_XTAL_KHZ_0;
         2'h1: dec.xtal_khz = `BSS_XTAL_KHZ_1;
         2'h2: dec.xtal_khz = `BSS_XTAL_KHZ_2;
         2'h3: dec.xtal_khz = `BSS_XTAL_KHZ_3;
      endcase
      dec.rsv_err = strap[`BSS_RSV_MSB:`BSS_RSV_LSB] != `BSS_RSV_OK;
      dec.aux_en = strap[`BSS_AUX_BIT]; // see [R5]
      // Patterns other than the two known ones leave the order empty
      case (strap[`BSS_PAT_MSB:`BSS_PAT_LSB]) // see [R4]
         `BSS_PAT_DEFAULT: begin
            dec.order_known = 1'b1;
            dec.order[0] = SRC_ONBOARD_FLASH; // see [R6]
            dec.order[1] = SRC_REMOVABLE_CARD;
            dec.order[2] = SRC_FIRST_SERIAL;
            dec.order[3] = SRC_FIRST_USB;
         end
         `BSS_PAT_ALT: begin
            dec.order_known = 1'b1;
            dec.order[0] = SRC_FIRST_SPI; // see [R7]
            dec.order[1] = SRC_REMOVABLE_CARD;
            dec.order[2] = SRC_FIRST_USB;
            dec.order[3] = SRC_FIRST_SERIAL;
         end
         default: begin
            dec.order_known = 1'b0;
         end
      endcase
   end

endmodule : bss_boot_decode

// File: bss_top.sv
/*
 Boot strap source select: captures the strap word after reset, decodes
 crystal rate, auxiliary clock enable and boot order, and exposes them
 over an AHB-Lite slave. Software picks which boot attempt is current
 and may force the auxiliary clock off.
 Assumes one 200 MHz clock, strap pins synchronous and settled at reset
 release, and a single-master AHB-Lite bus doing word transfers.
*/
// Summary of operation
// [R1] Read straps at power-up to pick order
// [R2] Bits 15:14 select crystal 19.2/24/25/26 MHz
// [R3] Board must strap bits 13:12 to 00b
// [R4] Bits 11:6 do not affect boot decode
// [R5] Bit 5 gates the auxiliary clock output
// [R6] 11100b: flash, card, serial, USB
// [R7] 11000b: SPI, card, USB, serial
// [R8] Boot switch pulls one strap bit low
// [R9] Header overrides released with board reset; board model drives them two cycles past release
// [R10] Captured straps held until next reset
`include "bss_params.svh"
module bss_top import bss_pkg::*; (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [`BSS_STRAP_W-1:0] boot_strap_bus,
   output logic strap_valid,
   output logic [15:0] xtal_khz,
   output logic strap_reserved_error,
   output logic boot_order_known,
   output bss_order_t boot_order,
   output bss_src_e boot_source,
   output logic aux_clock_output
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      bss_state_e state;
      logic [`BSS_STRAP_W-1:0] strap;
      bss_decode_s dec;
      logic [1:0] attempt;
      logic aux_off;
      bss_src_e cur_src;
      logic aux_out;
      bss_dphase_s dp;
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
   } bss_top_s;

   bss_top_s r_reg;
   bss_top_s r_next;
   logic cap_done;
   logic [`BSS_STRAP_W-1:0] cap_value;
   bss_decode_s dec_out;

   // ------------------------------------------------------------------
   // Capture and decode
   // ------------------------------------------------------------------
   bss_strap_capture u_capture (
      .hclk(hclk),
      .hresetn(hresetn),
      .boot_strap_bus(boot_strap_bus),
      .cap_done(cap_done),
      .cap_value(cap_value)
   );

   bss_boot_decode u_decode (
      .strap(cap_value),
      .dec(dec_out)
   );

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   // Zero-wait slave: read data is built from the next state so that a
   // read right after a control write already sees the new value
   always_comb begin
      r_next = r_reg;
      r_next.hreadyout = 1'b1;
      r_next.hresp = 1'b0;
      // Decoded word is latched once and then frozen
      unique case (r_reg.state)
         ST_CAPTURE: begin
            if (cap_done) begin
               r_next.state = ST_RUN; // see [R1]
               r_next.strap = cap_value;
               r_next.dec = dec_out;
            end
         end
         ST_RUN: begin
            r_next.state = ST_RUN; // see [R10]
         end
      endcase
      // Data phase of a word write to the control register
      if (r_reg.dp.sel && r_reg.dp.write && r_reg.dp.mapped &&
          r_reg.dp.word && r_reg.dp.addr == `BSS_OFF_CONTROL) begin
         r_next.attempt = hwdata[`BSS_CTL_ATT_MSB:`BSS_CTL_ATT_LSB];
         r_next.aux_off = hwdata[`BSS_CTL_AUXOFF];
      end
      // Current source follows the captured order and attempt index
      if (r_next.state == ST_RUN) begin
         r_next.cur_src = r_next.dec.order[r_next.attempt]; // see [R1]
      end else begin
         r_next.cur_src = SRC_NONE;
      end
      // Clock stays off until straps are known, whatever software asks
      r_next.aux_out = (r_next.state == ST_RUN) & r_next.dec.aux_en &
                       ~r_next.aux_off; // see [R5]
      // Address phase
      r_next.dp.sel = hsel & htrans[1] & hready;
      r_next.dp.write = hwrite;
      r_next.dp.mapped = haddr[31:4] == 28'h0;
      r_next.dp.word = hsize == `BSS_HSIZE_WORD;
      r_next.dp.addr = haddr[3:0];
      // Unmapped or other offsets read as zero
      r_next.hrdata = 32'h0;
      if (r_next.dp.sel && !hwrite && r_next.dp.mapped) begin
         case (haddr[3:0])
            `BSS_OFF_STRAP: begin
               r_next.hrdata[`BSS_STRAP_W-1:0] = r_next.strap;
            end
            `BSS_OFF_STATUS: begin
               r_next.hrdata[`BSS_ST_XTAL_MSB:`BSS_ST_XTAL_LSB] =
                  r_next.dec.xtal_khz;
               r_next.hrdata[`BSS_ST_AUX] = r_next.dec.aux_en;
               r_next.hrdata[`BSS_ST_RSVERR] = r_next.dec.rsv_err;
               r_next.hrdata[`BSS_ST_KNOWN] = r_next.dec.order_known;
               r_next.hrdata[`BSS_ST_VALID] = r_next.state == ST_RUN;
            end
            `BSS_OFF_ORDER: begin
               r_next.hrdata[`BSS_ORD_MSB:0] = r_next.dec.order;
            end
            `BSS_OFF_CONTROL: begin
               r_next.hrdata[`BSS_CTL_ATT_MSB:`BSS_CTL_ATT_LSB] =
                  r_next.attempt;
               r_next.hrdata[`BSS_CTL_AUXOFF] = r_next.aux_off;
            end
            default: begin
               r_next.hrdata = 32'h0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   // Reset gives constants only; straps are taken by the capture unit
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r_reg <= '0;
         r_reg.state <= ST_CAPTURE;
         r_reg.attempt <= `BSS_CTL_ATT_RST;
         r_reg.aux_off <= `BSS_CTL_AUXOFF_RST;
         r_reg.hreadyout <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   // Outputs straight from the state register
   assign hrdata = r_reg.hrdata;
   assign hreadyout = r_reg.hreadyout;
   assign hresp = r_reg.hresp;
   assign strap_valid = r_reg.state[1]; // One-hot bit of ST_RUN
   assign xtal_khz = r_reg.dec.xtal_khz;
   assign strap_reserved_error = r_reg.dec.rsv_err;
   assign boot_order_known = r_reg.dec.order_known;
   assign boot_order = r_reg.dec.order;
   assign boot_source = r_reg.cur_src;
   assign aux_clock_output = r_reg.aux_out;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   a_capture_to_run: assert property ( // see [R1]
      @(posedge hclk) disable iff (!hresetn)
      $rose(cap_done) |=> r_reg.state == ST_RUN &&
                          r_reg.strap == $past(cap_value))
      else $error("strap word not taken one cycle after capture");

   a_strap_frozen: assert property ( // see [R10]
      @(posedge hclk) disable iff (!hresetn)
      r_reg.state == ST_RUN |=> r_reg.state == ST_RUN &&
                                $stable(r_reg.strap) && $stable(r_reg.dec))
      else $error("captured straps changed after capture");

   a_xtal_decode: assert property ( // see [R2]
      @(posedge hclk) disable iff (!hresetn)
      r_reg.state == ST_RUN |->
         r_reg.dec.xtal_khz ==
         (r_reg.strap[15:14] == 2'h0 ? 16'h4B00 :
          r_reg.strap[15:14] == 2'h1 ? 16'h5DC0 :
          r_reg.strap[15:14] == 2'h2 ? 16'h61A8 : 16'h6590))
      else $error("crystal rate does not match strap code");

   a_dont_care: assert property ( // see [R4]
      @(posedge hclk) disable iff (!hresetn)
      r_reg.state == ST_RUN |->
         r_reg.dec.order_known == (r_reg.strap[4:0] == 5'h1C ||
                                   r_reg.strap[4:0] == 5'h18))
      else $error("order validity depends on more than bits 4:0");

   a_aux_enable: assert property ( // see [R5]
      @(posedge hclk) disable iff (!hresetn)
      aux_clock_output == (r_reg.state == ST_RUN && r_reg.strap[5] &&
                           !r_reg.aux_off))
      else $error("auxiliary clock enable does not follow strap bit 5");

   a_default_order: assert property ( // see [R6]
      @(posedge hclk) disable iff (!hresetn)
      r_reg.state == ST_RUN && r_reg.strap[4:0] == 5'h1C |->
         boot_order[0] == SRC_ONBOARD_FLASH &&
         boot_order[1] == SRC_REMOVABLE_CARD &&
         boot_order[2] == SRC_FIRST_SERIAL &&
         boot_order[3] == SRC_FIRST_USB)
      else $error("default boot order wrong");

   a_alt_order: assert property ( // see [R7]
      @(posedge hclk) disable iff (!hresetn)
      r_reg.state == ST_RUN && r_reg.strap[4:0] == 5'h18 |->
         boot_order[0] == SRC_FIRST_SPI &&
         boot_order[1] == SRC_REMOVABLE_CARD &&
         boot_order[2] == SRC_FIRST_USB &&
         boot_order[3] == SRC_FIRST_SERIAL)
      else $error("alternate boot order wrong");

   a_source_select: assert property ( // see [R1]
      @(posedge hclk) disable iff (!hresetn)
      r_reg.state == ST_RUN |-> boot_source == boot_order[r_reg.attempt])
      else $error("current boot source not taken from the order");

   // ------------------------------------------------------------------
   // Bus and hold checks
   // ------------------------------------------------------------------
   a_bus_okay: assert property ( // see [R1]
      @(posedge hclk) disable iff (!hresetn)
      hreadyout && !hresp)
      else $error("bus answer is not zero-wait OKAY");

   a_idle_read_zero: assert property ( // see [R1]
      @(posedge hclk) disable iff (!hresetn)
      !(hsel && htrans[1] && hready && !hwrite) |=> hrdata == 32'h0)
      else $error("read data not zero outside a read data phase");

   // Status word must carry the frozen decode, not a fresh one
   a_status_read: assert property ( // see [R1]
      @(posedge hclk) disable iff (!hresetn)
      hsel && htrans[1] && hready && !hwrite &&
      haddr == {28'h0, `BSS_OFF_STATUS} |=>
         hrdata[`BSS_ST_VALID] == (r_reg.state == ST_RUN) &&
         hrdata[`BSS_ST_XTAL_MSB:`BSS_ST_XTAL_LSB] == r_reg.dec.xtal_khz)
      else $error("status read does not show the captured decode");

   a_valid_level: assert property ( // see [R10]
      @(posedge hclk) disable iff (!hresetn)
      strap_valid |=> strap_valid)
      else $error("valid strap word lost without a reset");

   a_capture_once: assert property ( // see [R10]
      @(posedge hclk) disable iff (!hresetn)
      cap_done |=> cap_done && $stable(cap_value))
      else $error("capture unit sampled the pins a second time");

   a_no_source_early: assert property ( // see [R1]
      @(posedge hclk) disable iff (!hresetn)
      r_reg.state == ST_CAPTURE |->
         boot_source == SRC_NONE && !aux_clock_output && !strap_valid)
      else $error("boot source or clock shown before straps are known");

   a_unknown_empty: assert property ( // see [R4]
      @(posedge hclk) disable iff (!hresetn)
      r_reg.state == ST_RUN && !boot_order_known |->
         boot_order == '0 && boot_source == SRC_NONE)
      else $error("unknown strap pattern left a boot order behind");

   a_ignored_bits: assert property ( // see [R4]
      @(posedge hclk) disable iff (!hresetn)
      r_reg.state == ST_RUN |->
         r_reg.dec.order_known == (r_reg.strap[4:3] == 2'h3 &&
                                   r_reg.strap[1:0] == 2'h0))
      else $error("order decode depends on bits outside 4:0");

   a_ctrl_write: assert property ( // see [R1]
      @(posedge hclk) disable iff (!hresetn)
      r_reg.dp.sel && r_reg.dp.write && r_reg.dp.mapped && r_reg.dp.word &&
      r_reg.dp.addr == `BSS_OFF_CONTROL |=>
         r_reg.attempt == $past(hwdata[`BSS_CTL_ATT_MSB:`BSS_CTL_ATT_LSB]) &&
         r_reg.aux_off == $past(hwdata[`BSS_CTL_AUXOFF]))
      else $error("control write did not land");

   a_write_refused: assert property ( // see [R1]
      @(posedge hclk) disable iff (!hresetn)
      !(r_reg.dp.sel && r_reg.dp.write && r_reg.dp.mapped &&
        r_reg.dp.word && r_reg.dp.addr == `BSS_OFF_CONTROL) |=>
         $stable(r_reg.attempt) && $stable(r_reg.aux_off))
      else $error("control word changed without a word write");

endmodule : bss_top

// File: bss_strap_board.sv
/*
 Board side of the strap pins: resistors, boot switch, header driver.
 Assumes hclk is the device clock and board_reset_low the board reset.
*/
module bss_strap_board (
   input wire logic hclk,
   input wire logic board_reset_low,
   input wire logic boot_switch,
   input wire logic [1:0] xtal_code,
   input wire logic aux_strap,
   input wire logic hdr_en,
   input wire logic [15:0] hdr_value,
   output logic [15:0] boot_strap_bus
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] hold_cnt;
   logic [15:0] resistor_word;

   // Header drive lingers two cycles after release, then lets go
   always_ff @(posedge hclk or negedge board_reset_low) begin
      if (!board_reset_low) begin
         hold_cnt <= 2'h0;
      end else if (hold_cnt != 2'h2) begin
         hold_cnt <= hold_cnt + 2'h1;
      end
   end

   // Resistor levels, switch pull-down, then the gated header override
   always_comb begin
      resistor_word = {xtal_code, 2'h0, 6'h2A, aux_strap, 5'h1C};
      if (boot_switch) resistor_word[2] = 1'b0;
      boot_strap_bus = resistor_word;
      if (hdr_en && hold_cnt != 2'h2) boot_strap_bus = hdr_value;
   end
endmodule : bss_strap_board

// File: tb_top.sv
/*
 Self-checking bench for the boot strap source select block.
 Assumes the package and params header compile first; single clock.
*/
`include "bss_params.svh"
module tb_top import bss_pkg::*; ;
   timeunit 1ns;
   timeprecision 100ps;
   logic hclk;
   logic hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0] htrans = 2'h0, xtal_code = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic hreadyout, hresp, sw = 1'b0, aux = 1'b0, hdr_en = 1'b0;
   logic [15:0] hdr_value = 16'h0, strap, xtal_khz, w;
   logic strap_valid, strap_reserved_error, boot_order_known, aux_out;
   bss_order_t boot_order;
   bss_src_e boot_source;
   int err_count = 0, comparisons = 0;
   integer seed = 32'h57A5;

   bss_strap_board u_board (.hclk(hclk), .board_reset_low(hresetn),
      .boot_switch(sw), .xtal_code(xtal_code), .aux_strap(aux),
      .hdr_en(hdr_en), .hdr_value(hdr_value), .boot_strap_bus(strap));
   bss_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .boot_strap_bus(strap),
      .strap_valid(strap_valid), .xtal_khz(xtal_khz),
      .strap_reserved_error(strap_reserved_error),
      .boot_order_known(boot_order_known), .boot_order(boot_order),
      .boot_source(boot_source), .aux_clock_output(aux_out));

   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   // ------------------------------------------------------------------
   // Expectations and shared tasks
   // ------------------------------------------------------------------
   function automatic logic [15:0] exp_khz(input logic [1:0] c);
      case (c)
         2'h0: return `BSS_XTAL_KHZ_0;
         2'h1: return `BSS_XTAL_KHZ_1;
         2'h2: return `BSS_XTAL_KHZ_2;
         default: return `BSS_XTAL_KHZ_3;
      endcase
   endfunction : exp_khz

   // Slot 0 tried first; unknown patterns give an empty order
   function automatic logic [11:0] exp_order(input logic [4:0] p);
      if (p == 5'h1C) return {SRC_FIRST_USB, SRC_FIRST_SERIAL,
         SRC_REMOVABLE_CARD, SRC_ONBOARD_FLASH};
      if (p == 5'h18) return {SRC_FIRST_SERIAL, SRC_FIRST_USB,
         SRC_REMOVABLE_CARD, SRC_FIRST_SPI};
      return 12'h000;
   endfunction : exp_order

   task automatic chk(input string what, input logic [31:0] seen,
         input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // One single AHB-Lite transfer; read data taken at the data-phase edge
   task automatic ahb(input logic wr, input logic [31:0] a,
         input logic [2:0] sz, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= sz;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      chk("hresp", {31'h0, hresp}, 32'h0);
   endtask : ahb

   task automatic apply_reset(input logic he, input logic [15:0] hv,
         input logic s, input logic [1:0] xc, input logic ax);
      @(posedge hclk);
      hresetn <= 1'b0;
      hdr_en <= he;
      hdr_value <= hv;
      sw <= s;
      xtal_code <= xc;
      aux <= ax;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      // Still capturing here: nothing may show before edge two
      chk("valid early", {31'h0, strap_valid}, 32'h0);
      chk("aux early", {31'h0, aux_out}, 32'h0);
      @(posedge hclk);
      // Pins move after capture; the decode must not follow them
      sw <= ~s;
      xtal_code <= ~xc;
      aux <= ~ax;
      repeat (2) @(posedge hclk);
   endtask : apply_reset

   task automatic check_all(input logic [15:0] wd);
      logic [11:0] ord;
      logic kn;
      ord = exp_order(wd[4:0]);
      kn = (wd[4:0] == 5'h1C) || (wd[4:0] == 5'h18);
      chk("strap_valid", {31'h0, strap_valid}, 32'h1);
      chk("xtal_khz", {16'h0, xtal_khz},
         {16'h0, exp_khz(wd[15:14])});
      chk("rsv_err", {31'h0, strap_reserved_error},
         {31'h0, |wd[13:12]});
      chk("known", {31'h0, boot_order_known}, {31'h0, kn});
      chk("order", {20'h0, boot_order}, {20'h0, ord});
      chk("source", {29'h0, boot_source}, {29'h0, ord[2:0]});
      chk("aux_out", {31'h0, aux_out}, {31'h0, wd[5]});
      ahb(1'b0, 32'h0, 3'h2, 32'h0);
      chk("STRAP reg", rd, {16'h0, wd});
      ahb(1'b0, 32'h4, 3'h2, 32'h0);
      chk("STATUS reg", rd, {12'h0, 1'b1, kn, |wd[13:12], wd[5],
         exp_khz(wd[15:14])});
      ahb(1'b0, 32'h8, 3'h2, 32'h0);
      chk("ORDER reg", rd, {20'h0, ord});
      ahb(1'b0, 32'hC, 3'h2, 32'h0);
      chk("CONTROL rst", rd, 32'h0);
   endtask : check_all

   task automatic print_verdict();
      $display("Counts: comparisons %0d mismatches %0d", comparisons,
         err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : print_verdict

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      logic [1:0] att;
      logic aoff;
      logic [31:0] cv;
      // Switch held: one bit pulled low selects the alternate order
      apply_reset(1'b0, 16'h0, 1'b1, 2'h1, 1'b1);
      check_all({2'h1, 2'h0, 6'h2A, 1'b1, 5'h18});
      $display("Test boot_switch done");
      apply_reset(1'b0, 16'h0, 1'b0, 2'h3, 1'b0);
      check_all({2'h3, 2'h0, 6'h2A, 1'b0, 5'h1C});
      $display("Test default_straps done");
      for (int i = 0; i < 12; i++) begin
         w = 16'($random(seed));
         if (i % 3 == 0) w[4:0] = 5'h1C;
         if (i % 3 == 1) w[4:0] = 5'h18;
         apply_reset(1'b1, w, w[2], w[15:14], ~w[5]);
         check_all(w);
         att = i[1:0];
         aoff = i[2];
         cv = {23'h0, aoff, 6'h0, att};
         ahb(1'b1, {28'h0, `BSS_OFF_CONTROL}, 3'h2, cv);
         @(posedge hclk);
         chk("source att", {29'h0, boot_source},
            {29'h0, 3'(exp_order(w[4:0]) >> (att * 3))});
         chk("aux_off", {31'h0, aux_out}, {31'h0, w[5] & ~aoff});
         // Byte write and write to a read-only word must be ignored
         ahb(1'b1, 32'hC, 3'h0, ~cv);
         ahb(1'b1, 32'h0, 3'h2, 32'hFFFFFFFF);
         ahb(1'b0, 32'hC, 3'h2, 32'h0);
         chk("CONTROL rd", rd, cv);
         ahb(1'b0, 32'h0, 3'h2, 32'h0);
         chk("STRAP ro", rd, {16'h0, w});
         ahb(1'b0, 32'h10, 3'h2, 32'h0);
         chk("unmapped", rd, 32'h0);
         $display("Test random_%0d done", i);
      end
      print_verdict();
   end

   // Whole run is well under 3000 cycles; this cuts a hang short
   initial begin
      repeat (20000) @(posedge hclk);
      err_count++;
      $display("ERROR watchdog expected finish seen timeout");
      print_verdict();
   end
endmodule : tb_top
